// file: rtl/sfdp_param_table.sv
// sfdp_param_table: read-only flash parameter table behind a byte register port
// assumes: strobes are single cycles, never both at once; read data one cycle later
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none

module sfdp_param_table
   import sfdp_pkg::*;
#(
   parameter logic [31:0] FLASH_DENSITY = DENSITY_DEFAULT
)
(
   input wire logic clk,
   input wire logic rst,
   input wire sfdp_req_t req,
   output logic [7:0] rdData
);

   // ==========================================================
   // declarations
   sfdp_top_state_t st_r;
   sfdp_top_state_t st_nxt;
   logic [7:0] descParam [DESC_N];
   logic [7:0] descOpc [DESC_N];
   logic [DESC_N-1:0] descWait;
   logic [7:0] eraseCapByte;
   logic [7:0] rdCapByte;
   logic [7:0] wideCapByte;
   logic [7:0] tableByte;
   logic [7:0] readByte;
   logic [7:0] eraseOfs;
   logic [7:0] descOfs;
   logic [7:0] densOfs;
   logic [7:0] refusedCnt;
   logic refusedWrite;

   // ==========================================================
   // fast read descriptors
   genvar gi;
   generate
      for (gi = 0; gi < DESC_N; gi++) begin : g_desc
         sfdp_read_desc #(
            .WAIT_STATES(DESC_WAIT[gi]),
            .MODE_BITS(DESC_MODE[gi]),
            .OPCODE(DESC_OPC[gi])
         ) u_desc (
            .paramByte(descParam[gi]),
            .opcodeByte(descOpc[gi]),
            .waitUsed(descWait[gi])
         );
      end
   endgenerate

   // ==========================================================
   // capability bytes
   // erase and write capability
   assign eraseCapByte = {PAD3, VOL_WE_SEL, VOL_STATUS, WR_GRAN_64, ERASE_4K_CODE};

   // address width and lane support
   assign rdCapByte = {PAD1, FR114_OK, FR144_OK, FR122_OK, DTR_OK, ADDR_3BYTE_ONLY, FR112_OK};

   // double and quad lane support
   assign wideCapByte = {PAD3, FR444_OK, PAD3, FR222_OK};

   // ==========================================================
   // table lookup
   always_comb begin
      tableByte = BYTE_ONES;
      eraseOfs = req.addr - OFS_ERASE_BASE;
      descOfs = req.addr - OFS_DESC_BASE;
      densOfs = req.addr - OFS_DENSITY;
      if (req.addr == OFS_HDR_LEN) begin
         tableByte = HDR_LEN_DWORDS;
      end else if (req.addr == OFS_PTR_LO) begin
         tableByte = TABLE_START_POINTER[7:0];
      end else if (req.addr == OFS_PTR_MID) begin
         tableByte = TABLE_START_POINTER[15:8];
      end else if (req.addr == OFS_PTR_HI) begin
         tableByte = TABLE_START_POINTER[23:16];
      end else if (req.addr == OFS_ERASE_CAP) begin
         tableByte = eraseCapByte;
      end else if (req.addr == OFS_ERASE4K_OPC) begin
         tableByte = ERASE_OPC[0];
      end else if (req.addr == OFS_RD_CAP) begin
         tableByte = rdCapByte;
      end else if (req.addr >= OFS_DENSITY && req.addr < OFS_DESC_BASE) begin
         tableByte = FLASH_DENSITY[{densOfs[1:0], 3'h0} +: 8];
      end else if (req.addr >= OFS_DESC_BASE && req.addr < OFS_WIDE_CAP) begin
         // 1-4-4, 1-1-4, 1-1-2, 1-2-2 in pairs
         tableByte = descOfs[0] ? descOpc[descOfs[2:1]] : descParam[descOfs[2:1]];
      end else if (req.addr == OFS_WIDE_CAP) begin
         tableByte = wideCapByte;
      end else if (req.addr == OFS_DESC222) begin
         tableByte = descParam[D222];
      end else if (req.addr == OFS_DESC222_OPC) begin
         tableByte = descOpc[D222];
      end else if (req.addr == OFS_DESC444) begin
         tableByte = descParam[D444];
      end else if (req.addr == OFS_DESC444_OPC) begin
         tableByte = descOpc[D444];
      end else if (req.addr >= OFS_ERASE_BASE && req.addr <= OFS_TABLE_LAST) begin
         // size exponent then opcode for each erase type
         tableByte = eraseOfs[0] ? ERASE_OPC[eraseOfs[2:1]] : ERASE_SIZE[eraseOfs[2:1]];
      end
   end

   // ==========================================================
   // read mux
   always_comb begin
      if (req.addr == OFS_CTRL) begin
         readByte = {CTRL_PAD, st_r.tableEn};
      end else if (req.addr == OFS_REFUSED) begin
         readByte = refusedCnt;
      end else if (!st_r.tableEn) begin
         readByte = BYTE_ONES;
      end else begin
         readByte = tableByte;
      end
   end

   // ==========================================================
   // write side: only the control byte takes data
   assign refusedWrite = req.wrStb && req.addr != OFS_CTRL;

   sfdp_sat_count u_refused (
      .clk(clk),
      .rst(rst),
      .bump(refusedWrite),
      .count(refusedCnt)
   );

   // ==========================================================
   // state
   always_comb begin
      st_nxt = st_r;
      if (req.wrStb && req.addr == OFS_CTRL) begin
         st_nxt.tableEn = req.wrData[CTRL_EN_BIT];
      end
      if (req.rdStb) begin
         st_nxt.rdData = readByte;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= TOP_STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdData = st_r.rdData;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking

   default disable iff (rst);

   property p_reads(logic [7:0] a, logic [7:0] v);
      req.rdStb && req.addr == a && st_r.tableEn |=> rdData == v;
   endproperty

   sequence s_rd(logic [7:0] a);
      req.rdStb && req.addr == a && st_r.tableEn;
   endsequence

   a_erase_field: assert property (s_rd(OFS_ERASE_CAP) |=> rdData[1:0] == ERASE_4K_CODE)
      else $error("4 KB erase field wrong");

   a_write_gran: assert property (s_rd(OFS_ERASE_CAP) |=> rdData[2] && !rdData[3])
      else $error("granularity or status bit wrong");

   a_status_nonvol: assert property (s_rd(OFS_ERASE_CAP) |=> rdData[4:3] == 2'h0)
      else $error("status bits not reported nonvolatile");

   a_erase_byte: assert property (p_reads(OFS_ERASE_CAP, EXP_ERASE_CAP))
      else $error("byte 30H not E5H");

   a_pad_bits: assert property (s_rd(OFS_ERASE_CAP) ##1 1'b1 |-> rdData[7:5] == PAD3)
      else $error("unused bits of 30H not 111b");

   a_addr_width: assert property (s_rd(OFS_RD_CAP) |=> rdData[2:1] == 2'h0 && rdData == EXP_RD_CAP)
      else $error("byte 32H wrong");

   a_lane_support: assert property (s_rd(OFS_RD_CAP) |=> !rdData[3] && rdData[6:4] == 3'h7 && rdData[0])
      else $error("lane support bits wrong");

   a_desc144: assert property (s_rd(OFS_DESC_BASE) ##1 s_rd(OFS_DESC_BASE + 8'h01)
      |-> rdData == EXP_DESC[0] ##1 rdData == DESC_OPC[0])
      else $error("1-4-4 descriptor wrong");

   a_desc114: assert property (p_reads(OFS_DESC_BASE + 8'h02, EXP_DESC[1]))
      else $error("1-1-4 descriptor wrong");

   a_opc114: assert property (p_reads(OFS_DESC_BASE + 8'h03, DESC_OPC[1]))
      else $error("1-1-4 opcode wrong");

   a_desc112: assert property (p_reads(OFS_DESC_BASE + 8'h04, EXP_DESC[2]))
      else $error("1-1-2 descriptor wrong");

   a_opc112: assert property (p_reads(OFS_DESC_BASE + 8'h05, DESC_OPC[2]))
      else $error("1-1-2 opcode wrong");

   a_desc122: assert property (p_reads(OFS_DESC_BASE + 8'h06, EXP_DESC[3]))
      else $error("1-2-2 descriptor wrong");

   a_opc122: assert property (p_reads(OFS_DESC_BASE + 8'h07, DESC_OPC[3]))
      else $error("1-2-2 opcode wrong");

   a_wide_cap: assert property (p_reads(OFS_WIDE_CAP, EXP_WIDE_CAP))
      else $error("byte 40H not FEH");

   a_desc222: assert property (s_rd(OFS_DESC222) |=> rdData == EXP_DESC[D222] && !descWait[D222])
      else $error("2-2-2 descriptor not empty");

   a_desc444: assert property (s_rd(OFS_DESC444) |=> rdData == EXP_DESC[D444] && descWait[D444])
      else $error("4-4-4 descriptor wrong");

   a_opc444: assert property (p_reads(OFS_DESC444_OPC, DESC_OPC[D444]))
      else $error("4-4-4 opcode wrong");

   a_size_exp: assert property (req.rdStb && st_r.tableEn && req.addr >= OFS_ERASE_BASE
      && req.addr <= OFS_TABLE_LAST && !eraseOfs[0] |=> rdData == ERASE_ABSENT
      || (rdData >= ERASE_SIZE[0] && rdData < 8'h20))
      else $error("erase size byte not an exponent");

   a_erase_t1: assert property (s_rd(OFS_ERASE_BASE) ##1 s_rd(OFS_ERASE_BASE + 8'h01)
      |-> rdData == ERASE_SIZE[0] ##1 rdData == ERASE_OPC[0])
      else $error("erase type 1 wrong");

   a_erase_t2: assert property (p_reads(OFS_ERASE_BASE + 8'h02, ERASE_SIZE[1]))
      else $error("erase type 2 size wrong");

   a_erase_t3: assert property (p_reads(OFS_ERASE_BASE + 8'h05, ERASE_OPC[2]))
      else $error("erase type 3 opcode wrong");

   a_erase_t4: assert property (s_rd(OFS_ERASE_BASE + 8'h06) ##1 s_rd(OFS_TABLE_LAST)
      |-> rdData == ERASE_ABSENT ##1 rdData == BYTE_ONES)
      else $error("erase type 4 not absent");

   a_hdr_ptr: assert property (p_reads(OFS_PTR_LO, OFS_ERASE_CAP))
      else $error("table start pointer wrong");

   a_hdr_len: assert property (p_reads(OFS_HDR_LEN, HDR_LEN_DWORDS))
      else $error("table length wrong");

   a_unused_ones: assert property (req.rdStb && st_r.tableEn && (req.addr == OFS_RD_PAD
      || req.addr == OFS_WIDE_CAP + 8'h01) |=> rdData == BYTE_ONES)
      else $error("unused byte not FFH");

   a_write_inert: assert property (refusedWrite && !req.rdStb |=> $stable(rdData)
      && st_r.tableEn == $past(st_r.tableEn))
      else $error("write disturbed the table");

   a_hold_idle: assert property (!req.rdStb |=> $stable(rdData))
      else $error("read data moved without a read");

   // ==========================================================
   // checks of unused, control, header and single table bytes
   a_unused_sig: assert property (req.rdStb && st_r.tableEn
      && req.addr < OFS_HDR_LEN |=> rdData == BYTE_ONES)
      else $error("signature area not FFH");

   a_unused_gap: assert property (req.rdStb && st_r.tableEn
      && req.addr > OFS_PTR_HI && req.addr < OFS_ERASE_CAP |=> rdData == BYTE_ONES)
      else $error("gap before table not FFH");

   a_unused_wide: assert property (req.rdStb && st_r.tableEn
      && req.addr > OFS_WIDE_CAP && req.addr < OFS_DESC222 |=> rdData == BYTE_ONES)
      else $error("bytes 41H to 45H not FFH");

   a_unused_mid: assert property (req.rdStb && st_r.tableEn
      && req.addr > OFS_DESC222_OPC && req.addr < OFS_DESC444 |=> rdData == BYTE_ONES)
      else $error("bytes 48H to 49H not FFH");

   a_unused_top: assert property (req.rdStb && st_r.tableEn
      && (req.addr > OFS_TABLE_LAST && req.addr < OFS_CTRL || req.addr > OFS_REFUSED) |=> rdData == BYTE_ONES)
      else $error("byte past table not FFH");

   a_disabled_ones: assert property (req.rdStb && !st_r.tableEn
      && req.addr != OFS_CTRL && req.addr != OFS_REFUSED |=> rdData == BYTE_ONES)
      else $error("disabled table not FFH");

   a_ctrl_read: assert property (req.rdStb && req.addr == OFS_CTRL |=> rdData == {CTRL_PAD, $past(st_r.tableEn)})
      else $error("control byte read wrong");

   a_ctrl_write: assert property (req.wrStb && req.addr == OFS_CTRL
      |=> st_r.tableEn == $past(req.wrData[CTRL_EN_BIT]))
      else $error("control write not taken");

   a_ctrl_hold: assert property (!(req.wrStb && req.addr == OFS_CTRL) |=> $stable(st_r.tableEn))
      else $error("enable moved without a control write");

   a_refused_read: assert property (req.rdStb && req.addr == OFS_REFUSED |=> rdData == $past(refusedCnt))
      else $error("refused count read wrong");

   a_refused_hold: assert property (!refusedWrite |=> $stable(refusedCnt))
      else $error("refused count moved");

   a_ptr_mid: assert property (p_reads(OFS_PTR_MID, TABLE_START_POINTER[15:8]))
      else $error("pointer middle byte wrong");

   a_ptr_hi: assert property (p_reads(OFS_PTR_HI, TABLE_START_POINTER[23:16]))
      else $error("pointer high byte wrong");

   a_erase4k_opc: assert property (p_reads(OFS_ERASE4K_OPC, ERASE_OPC[0]))
      else $error("byte 31H wrong");

   a_param144: assert property (p_reads(OFS_DESC_BASE, EXP_DESC[0]))
      else $error("byte 38H wrong");

   a_opc144: assert property (p_reads(OFS_DESC_BASE + 8'h01, DESC_OPC[0]))
      else $error("byte 39H wrong");

   a_opc222: assert property (p_reads(OFS_DESC222_OPC, DESC_OPC[D222]))
      else $error("byte 47H wrong");

   a_size_t1: assert property (p_reads(OFS_ERASE_BASE, ERASE_SIZE[0]))
      else $error("byte 4CH wrong");

   a_opc_t1: assert property (p_reads(OFS_ERASE_BASE + 8'h01, ERASE_OPC[0]))
      else $error("byte 4DH wrong");

   a_opc_t2: assert property (p_reads(OFS_ERASE_BASE + 8'h03, ERASE_OPC[1]))
      else $error("byte 4FH wrong");

   a_size_t3: assert property (p_reads(OFS_ERASE_BASE + 8'h04, ERASE_SIZE[2]))
      else $error("byte 50H wrong");

   a_size_t4: assert property (p_reads(OFS_ERASE_BASE + 8'h06, ERASE_ABSENT))
      else $error("byte 52H wrong");

   a_opc_t4: assert property (p_reads(OFS_TABLE_LAST, BYTE_ONES))
      else $error("byte 53H wrong");

   a_dens_low: assert property (p_reads(OFS_DENSITY, FLASH_DENSITY[7:0]))
      else $error("density low byte wrong");

   a_dens_high: assert property (p_reads(OFS_DENSITY + 8'h03, FLASH_DENSITY[31:24]))
      else $error("density high byte wrong");

   a_wide_bits: assert property (s_rd(OFS_WIDE_CAP) |=> !rdData[0] && rdData[4])
      else $error("wide read support bits wrong");

   c_read_e5: cover property (s_rd(OFS_ERASE_CAP) ##1 rdData == EXP_ERASE_CAP);

   c_back_to_back: cover property (s_rd(OFS_DESC_BASE) ##1 s_rd(OFS_DESC_BASE + 8'h01));

   c_refused: cover property (refusedWrite ##1 req.rdStb && req.addr == OFS_REFUSED);

   c_disabled: cover property (!st_r.tableEn && req.rdStb && req.addr == OFS_ERASE_CAP);

endmodule
`default_nettype wire

// file: rtl/sfdp_pkg.sv
// sfdp_pkg: constants, field layouts and types of the flash parameter table
// assumes: one clock, synchronous active-high reset, byte-wide register port
// How it works
// - erase-size field of 30H reads 01b
// - write granularity bit reads one
// - status protection bits reported nonvolatile
// - volatile-write bits zero, byte 30H is E5H
// - bits 7:5 of 30H always 111b
// - three-byte addressing only, byte 32H is F1H
// - no DTR; dual and quad reads supported
// - 1-4-4 read reports 44H and EBH
// - 1-1-4 read reports 08H and 6BH
// - 1-1-2 read reports 08H and 3BH
// - 1-2-2 read reports 42H and BBH
// - 2-2-2 absent, 4-4-4 present, byte 40H FEH
// - 4-4-4 read reports 44H and EBH
// - erase size byte is power-of-two exponent
// - erase type 1 is 0CH, 20H
// - erase type 2 is 0FH, 52H
// - erase type 3 is 10H, D8H
// - erase type 4 absent: 00H, FFH
// - header points to 30H, nine double words

package sfdp_pkg;

   // ==========================================================
   // register port
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic wrStb;
      logic rdStb;
   } sfdp_req_t;

   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [6:0] CTRL_PAD = 7'h00;
   localparam logic [7:0] OFS_CTRL = 8'hF0;
   localparam logic [7:0] OFS_REFUSED = 8'hF1;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;

   // ==========================================================
   // parameter header
   localparam logic [7:0] OFS_HDR_LEN = 8'h0B;
   localparam logic [7:0] HDR_LEN_DWORDS = 8'h09;
   localparam logic [7:0] OFS_PTR_LO = 8'h0C;
   localparam logic [7:0] OFS_PTR_MID = 8'h0D;
   localparam logic [7:0] OFS_PTR_HI = 8'h0E;
   localparam logic [23:0] TABLE_START_POINTER = 24'h000030;

   // ==========================================================
   // table offsets
   localparam logic [7:0] OFS_ERASE_CAP = 8'h30;
   localparam logic [7:0] OFS_ERASE4K_OPC = 8'h31;
   localparam logic [7:0] OFS_RD_CAP = 8'h32;
   localparam logic [7:0] OFS_RD_PAD = 8'h33;
   localparam logic [7:0] OFS_DENSITY = 8'h34;
   localparam logic [7:0] OFS_DESC_BASE = 8'h38;
   localparam logic [7:0] OFS_WIDE_CAP = 8'h40;
   localparam logic [7:0] OFS_DESC222 = 8'h46;
   localparam logic [7:0] OFS_DESC222_OPC = 8'h47;
   localparam logic [7:0] OFS_DESC444 = 8'h4A;
   localparam logic [7:0] OFS_DESC444_OPC = 8'h4B;
   localparam logic [7:0] OFS_ERASE_BASE = 8'h4C;
   localparam logic [7:0] OFS_TABLE_LAST = 8'h53;
   localparam logic [31:0] DENSITY_DEFAULT = 32'hFFFFFFFF;

   // ==========================================================
   // byte 30H fields
   localparam logic [1:0] ERASE_4K_CODE = 2'h1;
   localparam logic WR_GRAN_64 = 1'b1;
   localparam logic VOL_STATUS = 1'b0;
   localparam logic VOL_WE_SEL = 1'b0;
   localparam logic [2:0] PAD3 = 3'h7;

   // ==========================================================
   // byte 32H and 40H fields
   localparam logic FR112_OK = 1'b1;
   localparam logic [1:0] ADDR_3BYTE_ONLY = 2'h0;
   localparam logic DTR_OK = 1'b0;
   localparam logic FR122_OK = 1'b1;
   localparam logic FR144_OK = 1'b1;
   localparam logic FR114_OK = 1'b1;
   localparam logic PAD1 = 1'b1;
   localparam logic FR222_OK = 1'b0;
   localparam logic FR444_OK = 1'b1;

   // ==========================================================
   // fast read descriptors: 1-4-4, 1-1-4, 1-1-2, 1-2-2, 2-2-2, 4-4-4
   localparam int DESC_N = 6;
   localparam int D222 = 4;
   localparam int D444 = 5;
   localparam logic [4:0] DESC_WAIT [DESC_N] = '{5'h04, 5'h08, 5'h08, 5'h02, 5'h00, 5'h04};
   localparam logic [2:0] DESC_MODE [DESC_N] = '{3'h2, 3'h0, 3'h0, 3'h2, 3'h0, 3'h2};
   localparam logic [7:0] DESC_OPC [DESC_N] = '{8'hEB, 8'h6B, 8'h3B, 8'hBB, 8'hFF, 8'hEB};

   // ==========================================================
   // erase types 1 to 4
   localparam logic [7:0] ERASE_ABSENT = 8'h00;
   localparam logic [7:0] ERASE_SIZE [4] = '{8'h0C, 8'h0F, 8'h10, 8'h00};
   localparam logic [7:0] ERASE_OPC [4] = '{8'h20, 8'h52, 8'hD8, 8'hFF};

   // ==========================================================
   // whole-byte cross checks
   localparam logic [7:0] EXP_ERASE_CAP = 8'hE5;
   localparam logic [7:0] EXP_RD_CAP = 8'hF1;
   localparam logic [7:0] EXP_WIDE_CAP = 8'hFE;
   localparam logic [7:0] EXP_DESC [DESC_N] = '{8'h44, 8'h08, 8'h08, 8'h42, 8'h00, 8'h44};

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0] rdData;
      logic tableEn;
   } sfdp_top_state_t;

   typedef struct packed {
      logic [7:0] count;
   } sfdp_cnt_state_t;

   localparam sfdp_top_state_t TOP_STATE_RST = '{rdData: BYTE_ONES, tableEn: CTRL_EN_RST};
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_ONE = 8'h01;

endpackage

// file: rtl/sfdp_read_desc.sv
// sfdp_read_desc: packs one fast read descriptor into its two table bytes
// assumes: wait, mode and opcode fixed at elaboration
`timescale 1ns/100ps
`default_nettype none

module sfdp_read_desc
   import sfdp_pkg::*;
#(
   parameter logic [4:0] WAIT_STATES = 5'h00,
   parameter logic [2:0] MODE_BITS = 3'h0,
   parameter logic [7:0] OPCODE = 8'hFF
)
(
   output logic [7:0] paramByte,
   output logic [7:0] opcodeByte,
   output logic waitUsed
);

   // ==========================================================
   // packing
   assign paramByte = {MODE_BITS, WAIT_STATES};
   assign opcodeByte = OPCODE;
   assign waitUsed = (WAIT_STATES != 5'h00);

endmodule
`default_nettype wire

// file: rtl/sfdp_sat_count.sv
// sfdp_sat_count: saturating count of refused writes
// assumes: bump is a one-cycle pulse synchronous to clk
`timescale 1ns/100ps
`default_nettype none

module sfdp_sat_count
   import sfdp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic bump,
   output logic [7:0] count
);

   sfdp_cnt_state_t st_r;
   sfdp_cnt_state_t st_nxt;

   // ==========================================================
   // counter
   always_comb begin
      st_nxt = st_r;
      if (bump && st_r.count != CNT_MAX) begin
         st_nxt.count = st_r.count + CNT_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '{count: CNT_ZERO};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign count = st_r.count;

   // ==========================================================
   // checks
   a_refused_step: assert property (@(posedge clk) disable iff (rst)
      bump && count != CNT_MAX |=> count == $past(count) + CNT_ONE)
      else $error("refused write not counted");

   c_refused_sat: cover property (@(posedge clk) disable iff (rst) count == CNT_MAX);

endmodule
`default_nettype wire

// file: tb/sfdp_host_model.sv
// sfdp_host_model: host controller side of the parameter read port
// assumes: tasks are entered right after a rising edge of clk
`timescale 1ns/100ps
`default_nettype none

module sfdp_host_model
   import sfdp_pkg::*;
(
   input wire logic clk,
   output var sfdp_req_t req,
   input wire logic [7:0] rdData
);
   initial begin
      req = '{addr: 8'h00, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b0};
   end

   // ==========================================================
   // write: one strobe cycle, then one released cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req.addr <= a;
      req.wrData <= d;
      req.wrStb <= 1'b1;
      @(posedge clk);
      req.wrStb <= 1'b0;
      req.addr <= ~a;
      req.wrData <= ~d;
      @(posedge clk);
   endtask

   // ==========================================================
   // back-to-back parameter reads, each byte taken one edge later
   task automatic rdBurst(input logic [7:0] a[$], output logic [7:0] d[$]);
      d = {};
      foreach (a[i]) begin
         req.addr <= a[i];
         req.rdStb <= 1'b1;
         @(posedge clk);
         if (i > 0) d.push_back(rdData);
      end
      req.rdStb <= 1'b0;
      req.addr <= ~a[a.size() - 1];
      @(posedge clk);
      d.push_back(rdData);
   endtask
endmodule
`default_nettype wire

// file: tb/sfdp_param_table_tb_top.sv
// sfdp_param_table_tb_top: self-checking bench of the parameter table
// assumes: host model drives the port, bench keeps the expected state
`timescale 1ns/100ps
`default_nettype none

module sfdp_param_table_tb_top
   import sfdp_pkg::*;
;
   localparam logic [31:0] DENS = 32'h07FFFFFF;
   logic clk = 1'b0;
   logic rst = 1'b1;
   sfdp_req_t req;
   logic [7:0] rdData;
   int num_errors = 0;
   int comparisons = 0;
   integer seed = 78;
   logic en = 1'b1;
   logic [7:0] cnt = 8'h00;

   always #4 clk = ~clk;

   sfdp_param_table #(.FLASH_DENSITY(DENS)) DUT (.clk(clk), .rst(rst), .req(req), .rdData(rdData));
   sfdp_host_model host (.clk(clk), .req(req), .rdData(rdData));

   // ==========================================================
   // expected byte at an address
   function automatic logic [7:0] expByte(input logic [7:0] a, input logic e, input logic [7:0] c);
      if (a == 8'hF0) return {7'h00, e};
      if (a == 8'hF1) return c;
      if (!e) return 8'hFF;
      case (a)
         8'h0B: return 8'h09;
         8'h0C: return 8'h30;
         8'h0D, 8'h0E: return 8'h00;
         8'h30: return 8'hE5;
         8'h31: return 8'h20;
         8'h32: return 8'hF1;
         8'h34, 8'h35, 8'h36, 8'h37: return DENS[8 * (a - 8'h34) +: 8];
         8'h38, 8'h4A: return 8'h44;
         8'h39, 8'h4B: return 8'hEB;
         8'h3A, 8'h3C: return 8'h08;
         8'h3B: return 8'h6B;
         8'h3D: return 8'h3B;
         8'h3E: return 8'h42;
         8'h3F: return 8'hBB;
         8'h40: return 8'hFE;
         8'h46, 8'h52: return 8'h00;
         8'h4C: return 8'h0C;
         8'h4D: return 8'h20;
         8'h4E: return 8'h0F;
         8'h4F: return 8'h52;
         8'h50: return 8'h10;
         8'h51: return 8'hD8;
         default: return 8'hFF;
      endcase
   endfunction

   // ==========================================================
   // checks and bus helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] e, input string what);
      comparisons++;
      if (got !== e) begin
         num_errors++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, e);
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] aq[$];
      logic [7:0] dq[$];
      aq = {a};
      host.rdBurst(aq, dq);
      d = dq[0];
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(d, e, "table byte");
   endtask

   task automatic wrM(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      if (a == 8'hF0) en = d[0];
      else if (cnt != 8'hFF) cnt++;
   endtask

   task automatic walk();
      logic [7:0] aq[$];
      logic [7:0] dq[$];
      for (int i = 0; i < 256; i++) aq.push_back(8'(i));
      host.rdBurst(aq, dq);
      foreach (dq[i]) chk(dq[i], expByte(aq[i], en, cnt), "address walk");
   endtask

   task automatic wrap_up();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [7:0] d;
      logic [7:0] a;
      logic [1:0] op;
      repeat (10) @(posedge clk);
      chk(rdData, 8'hFF, "reset read data");
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h30, d);
      chk({6'h00, d[1:0]}, 8'h01, "erase code");
      chk({7'h00, d[2]}, 8'h01, "write granularity");
      chk({7'h00, d[3]}, 8'h00, "status volatility");
      chk({5'h00, d[7:5]}, 8'h07, "pad bits");
      chk(d, 8'hE5, "byte 30");
      rd(8'h32, d);
      chk({6'h00, d[2:1]}, 8'h00, "address bytes");
      chk({3'h0, d[6:4], d[3], d[0]}, 8'h1D, "read support");
      rdChk(8'h38, 8'h44);
      rdChk(8'h39, 8'hEB);
      rdChk(8'h3A, 8'h08);
      rdChk(8'h3B, 8'h6B);
      rdChk(8'h3C, 8'h08);
      rdChk(8'h3D, 8'h3B);
      rdChk(8'h3E, 8'h42);
      rdChk(8'h3F, 8'hBB);
      rdChk(8'h40, 8'hFE);
      rdChk(8'h46, 8'h00);
      rdChk(8'h47, 8'hFF);
      rdChk(8'h4A, 8'h44);
      rdChk(8'h4B, 8'hEB);
      rdChk(8'h4C, 8'($clog2(4096)));
      rdChk(8'h4D, 8'h20);
      rdChk(8'h4E, 8'($clog2(32768)));
      rdChk(8'h4F, 8'h52);
      rdChk(8'h50, 8'($clog2(65536)));
      rdChk(8'h51, 8'hD8);
      rdChk(8'h52, 8'h00);
      rdChk(8'h53, 8'hFF);
      rdChk(8'h0C, 8'h30);
      walk();
      wrM(8'h30, 8'h00);
      rdChk(8'h30, 8'hE5);
      rdChk(8'hF1, 8'h01);
      wrM(8'hF0, 8'hFE);
      walk();
      wrM(8'hF0, 8'hFF);
      rdChk(8'hF0, 8'h01);
      repeat (400) begin
         op = 2'($random(seed));
         a = 8'($random(seed));
         d = 8'($random(seed));
         if (a[7]) a = 8'h0B + {2'b00, a[5:0]};
         if (op == 2'h0) wrM(a, d);
         else if (op == 2'h1) wrM(8'hF0, d);
         else begin
            rd(a, d);
            chk(d, expByte(a, en, cnt), "random read");
         end
      end
      wrM(8'hF0, 8'h01);
      repeat (260) wrM(8'hF1, 8'h5A);
      rdChk(8'hF1, 8'hFF);
      walk();
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      en = 1'b1;
      cnt = 8'h00;
      rdChk(8'hF1, 8'h00);
      rdChk(8'hF0, 8'h01);
      rdChk(8'h30, 8'hE5);
      wrap_up();
   end

   // ==========================================================
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      wrap_up();
   end
endmodule
`default_nettype wire
